// *** pmc_main_ctrl.sv ***
// Main control and flag register group with link-clock access port
`timescale 1ns/1ps
`default_nettype none
module pmc_main_ctrl
  import pmc_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        lk_clk,
  input  wire logic        lk_req_valid,
  input  wire pmc_lreq_t   lk_req,
  output logic             lk_req_ready,
  output logic             lk_rsp_valid,
  output logic [15:0]      lk_rsp_rdata,
  input  wire pmc_src_t    src_flags,
  input  wire logic        pll_locked_in,
  input  wire logic        normal_state_in,
  input  wire logic        pgood_in,
  input  wire logic        wake_input_first,
  input  wire logic        wake_input_second,
  input  wire logic        otp_pgood_test_allow,
  input  wire logic        otp_deep_sleep_allow,
  input  wire logic        otp_standby_timer_enable,
  input  wire logic        stby_timer_flag_clr,
  output logic             standby_power_good_output,
  output logic             wake_first_wake,
  output logic             wake_second_wake,
  output logic             deep_sleep_request,
  output logic             external_sync_deselect,
  output logic             enter_off_command,
  output logic             standby_timer_expired,
  output pmc_rail_req_t    rail_req
);

  // Reset release, one synchroniser per domain
  logic rst_n;
  logic lk_rst_n;

  pmc_sync #(.W(1)) u_rst_m (
    .clk   (mclk),
    .rst_n (nrst),
    .d     (1'b1),
    .q     (rst_n)
  );

  pmc_sync #(.W(1)) u_rst_l (
    .clk   (lk_clk),
    .rst_n (nrst),
    .d     (1'b1),
    .q     (lk_rst_n)
  );

  // Link domain
  logic      lk_busy_ff;
  logic      req_tgl_ff;
  pmc_lreq_t lk_hold_ff;
  logic      ack_sync;
  logic      ack_seen_ff;
  logic      ack_evt;
  logic      lk_rsp_valid_ff;
  logic [15:0] lk_rdata_ff;
  logic      ack_tgl_ff;
  logic [15:0] rd_hold_ff;
  logic      take;

  assign lk_req_ready = !lk_busy_ff;
  assign take         = lk_req_valid && lk_req_ready;
  assign ack_evt      = ack_sync ^ ack_seen_ff;

  pmc_sync #(.W(1)) u_ack (
    .clk   (lk_clk),
    .rst_n (lk_rst_n),
    .d     (ack_tgl_ff),
    .q     (ack_sync)
  );

  // Request held stable until the core answers
  always_ff @(posedge lk_clk or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      lk_hold_ff <= '0;
      req_tgl_ff <= 1'b0;
    end else if (take) begin
      lk_hold_ff <= lk_req;
      req_tgl_ff <= ~req_tgl_ff;
    end
  end

  always_ff @(posedge lk_clk or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      lk_busy_ff <= 1'b0;
    end else if (take) begin
      lk_busy_ff <= 1'b1;
    end else if (ack_evt) begin
      lk_busy_ff <= 1'b0;
    end
  end

  // Read data is stable here: it was written on the same mclk edge that toggled the ack
  always_ff @(posedge lk_clk or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      ack_seen_ff     <= 1'b0;
      lk_rsp_valid_ff <= 1'b0;
      lk_rdata_ff     <= '0;
    end else begin
      ack_seen_ff     <= ack_sync;
      lk_rsp_valid_ff <= ack_evt;
      if (ack_evt) begin
        lk_rdata_ff <= rd_hold_ff;
      end
    end
  end

  assign lk_rsp_valid = lk_rsp_valid_ff;
  assign lk_rsp_rdata = lk_rdata_ff;

  // Core domain
  logic req_sync;
  logic req_seen_ff;
  logic acc;
  logic accept;
  logic wr_en;
  logic [15:0] wd;

  pmc_sync #(.W(1)) u_req (
    .clk   (mclk),
    .rst_n (rst_n),
    .d     (req_tgl_ff),
    .q     (req_sync)
  );

  pmc_src_t src;
  logic     pll_s;
  logic     normal_s;
  logic     pgood_s;
  logic     wake1_s;
  logic     wake2_s;
  logic     otp_test_s;
  logic     otp_dsm_s;
  logic     otp_tmr_s;

  pmc_sync #(.W($bits(pmc_src_t))) u_src (
    .clk   (mclk),
    .rst_n (rst_n),
    .d     (src_flags),
    .q     (src)
  );

  pmc_sync #(.W(8)) u_pins (
    .clk   (mclk),
    .rst_n (rst_n),
    .d     ({pll_locked_in, normal_state_in, pgood_in, wake_input_first,
             wake_input_second, otp_pgood_test_allow, otp_deep_sleep_allow,
             otp_standby_timer_enable}),
    .q     ({pll_s, normal_s, pgood_s, wake1_s, wake2_s, otp_test_s,
             otp_dsm_s, otp_tmr_s})
  );

  assign acc    = req_sync ^ req_seen_ff;
  // Fail-safe frames and failed checksums never reach the registers
  assign accept = acc && !lk_hold_ff.fs_sel && lk_hold_ff.crc_ok; // R22 R23
  assign wr_en  = accept && lk_hold_ff.wr;
  assign wd     = lk_hold_ff.wdata;

  // Mode register
  logic test_en_ff;
  logic w1_dis_ff;
  logic w2_dis_ff;
  logic test_lvl_ff;
  logic dsm_en_ff;
  logic ext_desel_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      test_en_ff  <= MODE_RST[MODE_TEST_EN];
      w1_dis_ff   <= MODE_RST[MODE_W1_DIS];
      w2_dis_ff   <= MODE_RST[MODE_W2_DIS];
      test_lvl_ff <= MODE_RST[MODE_TEST_LVL];
      dsm_en_ff   <= MODE_RST[MODE_DSM_EN];
    end else if (wr_en && lk_hold_ff.addr == ADDR_MODE) begin
      test_en_ff  <= wd[MODE_TEST_EN];
      w1_dis_ff   <= wd[MODE_W1_DIS];
      w2_dis_ff   <= wd[MODE_W2_DIS];
      test_lvl_ff <= wd[MODE_TEST_LVL];
      dsm_en_ff   <= wd[MODE_DSM_EN];
    end
  end

  // Write-one strobe; the bit itself is not stored
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_desel_ff <= 1'b0;
    end else begin
      ext_desel_ff <= wr_en && lk_hold_ff.addr == ADDR_MODE
                      && wd[MODE_EXT_DIS]; // R15
    end
  end

  // State machine control register
  logic [3:0] win_ff;
  logic       tmr_en_ff;
  logic       off_cmd_ff;
  logic [1:0] strap_cnt_ff;
  logic       strap_load;

  assign strap_load = (strap_cnt_ff == STRAP_SETTLE);

  // Strap is sampled only after its synchroniser has filled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_ff <= '0;
    end else if (strap_cnt_ff != STRAP_SETTLE + 2'h1) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      win_ff    <= WIN_RST;
      tmr_en_ff <= 1'b0;
    end else if (strap_load) begin
      tmr_en_ff <= otp_tmr_s; // R17
    end else if (wr_en && lk_hold_ff.addr == ADDR_SMCTL) begin
      win_ff    <= wd[SMCTL_WIN_LSB +: 4]; // R18
      tmr_en_ff <= wd[SMCTL_TMR_EN]; // R17
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      off_cmd_ff <= 1'b0;
    end else begin
      off_cmd_ff <= wr_en && lk_hold_ff.addr == ADDR_SMCTL
                    && wd[SMCTL_OFF]; // R16
    end
  end

  // Standby timer and its sticky expiry flag
  logic tmr_expired;
  logic stby_exp_ff;

  pmc_stby_timer #(.TICK_CYC(TICK_CYC)) u_tmr (
    .clk     (mclk),
    .rst_n   (rst_n),
    .run     (tmr_en_ff),
    .win_sel (win_ff),
    .expired (tmr_expired)
  );

  // Expiry arriving with a clear is kept
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stby_exp_ff <= 1'b0;
    end else if (tmr_expired) begin
      stby_exp_ff <= 1'b1;
    end else if (stby_timer_flag_clr) begin
      stby_exp_ff <= 1'b0;
    end
  end

  // Rail request strobes
  pmc_rail_req_t rail_ff;
  logic [RAIL_N-1:0] on_bits;
  logic [RAIL_N-1:0] off_bits;
  logic              rail_wr;

  assign rail_wr  = wr_en && lk_hold_ff.addr == ADDR_RAILREQ;
  assign on_bits  = wd[RAIL_EN_LSB +: RAIL_N];
  assign off_bits = wd[RAIL_DIS_LSB +: RAIL_N];

  // One-cycle pulses that clear themselves
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rail_ff <= '0;
    end else if (rail_wr) begin
      rail_ff.rail_on_req  <= on_bits & ~off_bits; // R19 R25
      rail_ff.rail_off_req <= off_bits; // R20 R25
      rail_ff.pre_regulator_off_request <= wd[RAIL_PRE_OFF]; // R21
    end else begin
      rail_ff <= '0; // R24
    end
  end

  // Pin-facing outputs
  logic pgood_ff;
  logic wake1_ff;
  logic wake2_ff;
  logic dsm_req_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pgood_ff <= 1'b0;
    end else if (test_en_ff && otp_test_s) begin
      pgood_ff <= test_lvl_ff; // R10
    end else begin
      pgood_ff <= pgood_s;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake1_ff   <= 1'b0;
      wake2_ff   <= 1'b0;
      dsm_req_ff <= 1'b0;
    end else begin
      wake1_ff   <= wake1_s && !w1_dis_ff; // R11
      wake2_ff   <= wake2_s && !w2_dis_ff; // R11
      dsm_req_ff <= wake2_s && dsm_en_ff && otp_dsm_s; // R12
    end
  end

  // Live summary word, no storage of its own
  pmc_flag_t flags;

  always_comb begin
    flags.die_temp_summary            = src.die_temp_flag; // R2
    flags.backup_supply_summary       = src.backup_uvh; // R2
    flags.comm_error_summary          = src.crc_err | src.req_err; // R1
    flags.wake_summary = src.wake_first_flag | src.wake_second_flag; // R3
    flags.pre_regulator_summary = src.pre_oc | src.pre_uvh
                                  | src.pre_uvl | src.pre_fb_ov; // R4
    flags.boost_summary               = src.boost_ot | src.boost_ov; // R5
    flags.buck_first_summary   = src.buck_oc[0] | src.buck_ot[0]; // R6
    flags.buck_second_summary  = src.buck_oc[1] | src.buck_ot[1]; // R6
    flags.buck_third_summary   = src.buck_oc[2] | src.buck_ot[2]; // R6
    flags.linear_first_summary  = src.ldo_oc[0] | src.ldo_ot[0]; // R6
    flags.linear_second_summary = src.ldo_oc[1] | src.ldo_ot[1]; // R6
    flags.linear_third_summary  = src.ldo_oc[2] | src.ldo_ot[2]; // R6
    flags.high_voltage_linear_summary = src.hv_oc | src.hv_ot
                                        | src.hv_in_uvl; // R7
    flags.standby_timer_summary       = stby_exp_ff; // R9
    flags.supply_summary = src.sup_uvh | src.sup_uvt | src.sup_uv7; // R8
    flags.thermal_selftest_summary    = src.tsd_bist_err; // R9
  end

  // Read multiplexer
  logic [15:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    unique case (lk_hold_ff.addr)
      ADDR_FLAG: begin
        rd_mux = flags; // R2
      end
      ADDR_MODE: begin
        rd_mux[MODE_TEST_EN]  = test_en_ff;
        rd_mux[MODE_W1_DIS]   = w1_dis_ff;
        rd_mux[MODE_W2_DIS]   = w2_dis_ff;
        rd_mux[MODE_TEST_LVL] = test_lvl_ff;
        rd_mux[MODE_DSM_EN]   = dsm_en_ff;
        rd_mux[MODE_NORMAL]   = normal_s; // R13
        rd_mux[MODE_PLL_LOCK] = pll_s; // R14
      end
      ADDR_SMCTL: begin
        rd_mux[SMCTL_WIN_LSB +: 4] = win_ff;
        rd_mux[SMCTL_TMR_EN]       = tmr_en_ff;
      end
      default: begin
        rd_mux = '0; // R24
      end
    endcase
  end

  // Answer: capture read data and toggle the ack on the same edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      req_seen_ff <= 1'b0;
      ack_tgl_ff  <= 1'b0;
      rd_hold_ff  <= '0;
    end else begin
      req_seen_ff <= req_sync;
      if (acc) begin
        ack_tgl_ff <= ~ack_tgl_ff;
        rd_hold_ff <= (accept && !lk_hold_ff.wr) ? rd_mux : 16'h0000;
      end
    end
  end

  assign standby_power_good_output = pgood_ff;
  assign wake_first_wake           = wake1_ff;
  assign wake_second_wake          = wake2_ff;
  assign deep_sleep_request        = dsm_req_ff;
  assign external_sync_deselect    = ext_desel_ff;
  assign enter_off_command         = off_cmd_ff;
  assign standby_timer_expired     = stby_exp_ff;
  assign rail_req                  = rail_ff;

endmodule // pmc_main_ctrl
`default_nettype wire

// *** pmc_pkg.sv ***
// Constants, types and layout of the main control and flag register group
// Function
// R1: Communication error summary is set while checksum or invalid-request error is active.
// R2: Every summary flag is a live OR of its sources; 1 event, 0 none.
// R3: Wake summary is set while either wake input flag is set.
// R4: Pre-regulator summary ORs overcurrent, high/low undervoltage and feedback overvoltage.
// R5: Boost summary ORs boost overtemperature and boost overvoltage.
// R6: Each buck and low-dropout rail summary ORs its overcurrent and overtemperature.
// R7: High-voltage linear summary ORs overcurrent, overtemperature and input undervoltage.
// R8: Supply summary ORs high undervoltage, threshold undervoltage and 7 V undervoltage.
// R9: Standby timer and thermal self-test summaries mirror their single source flags.
// R10: Power-good test enable, when permitted, drives standby power-good to test level.
// R11: A wake disable bit at 1 stops that wake input waking the device.
// R12: With deep sleep permitted, request enable lets second wake input request deep sleep.
// R13: A read-only bit shows 1 while the main state machine is normal.
// R14: A read-only bit shows whether the internal PLL is locked.
// R15: Writing 1 to external sync disable deselects external sync; 0 does nothing.
// R16: Writing 1 to the enter-off command moves the device to off; 0 nothing.
// R17: Standby timer runs only while enabled; enable resets from one-time configuration.
// R18: Four-bit window code selects 16 ms up to 8388608 ms durations.
// R19: Writing 1 to a rail enable-request bit requests that rail turn on.
// R20: Writing 1 to a rail disable-request bit requests that rail turn off.
// R21: Writing 1 to the pre-regulator disable-request bit requests pre-regulator off.
// R22: Host addresses main logic with the main/fail-safe select bit cleared.
// R23: Every access carries an 8-bit checksum, polynomial 0x1D, seed 0xFF.
// R24: Rail request register is write-only strobes; reads return zero.
// R25: Enable and disable for one rail together: disable wins, rail stays off.
package pmc_pkg;

  localparam int unsigned MCLK_KHZ    = 20000;
  localparam int unsigned TICK_MS     = 1;
  localparam int unsigned TICK_CYCLES = MCLK_KHZ * TICK_MS;

  localparam logic [5:0] ADDR_FLAG    = 6'h00;
  localparam logic [5:0] ADDR_MODE    = 6'h01;
  localparam logic [5:0] ADDR_SMCTL   = 6'h02;
  localparam logic [5:0] ADDR_RAILREQ = 6'h03;

  localparam int MODE_TEST_EN  = 0;
  localparam int MODE_W1_DIS   = 1;
  localparam int MODE_W2_DIS   = 2;
  localparam int MODE_TEST_LVL = 3;
  localparam int MODE_DSM_EN   = 4;
  localparam int MODE_NORMAL   = 5;
  localparam int MODE_EXT_DIS  = 6;
  localparam int MODE_PLL_LOCK = 7;

  localparam int SMCTL_OFF     = 0;
  localparam int SMCTL_TMR_EN  = 10;
  localparam int SMCTL_WIN_LSB = 12;

  localparam int RAIL_EN_LSB   = 0;
  localparam int RAIL_DIS_LSB  = 8;
  localparam int RAIL_PRE_OFF  = 15;
  localparam int RAIL_N        = 7;

  localparam logic [3:0]  WIN_RST      = 4'h0;
  localparam logic [15:0] MODE_RST     = 16'h0000;
  localparam logic [1:0]  STRAP_SETTLE = 2'h2;

  localparam logic [23:0] WIN_MS [16] = '{
    24'h000010, 24'h000020, 24'h000080, 24'h000200,
    24'h000400, 24'h001000, 24'h002000, 24'h004000,
    24'h010000, 24'h020000, 24'h040000, 24'h080000,
    24'h100000, 24'h200000, 24'h400000, 24'h800000};

  typedef struct packed {
    logic       die_temp_flag;
    logic       backup_uvh;
    logic       crc_err;
    logic       req_err;
    logic       wake_first_flag;
    logic       wake_second_flag;
    logic       pre_oc;
    logic       pre_uvh;
    logic       pre_uvl;
    logic       pre_fb_ov;
    logic       boost_ot;
    logic       boost_ov;
    logic [2:0] buck_oc;
    logic [2:0] buck_ot;
    logic [2:0] ldo_oc;
    logic [2:0] ldo_ot;
    logic       hv_oc;
    logic       hv_ot;
    logic       hv_in_uvl;
    logic       sup_uvh;
    logic       sup_uvt;
    logic       sup_uv7;
    logic       tsd_bist_err;
  } pmc_src_t;

  typedef struct packed {
    logic die_temp_summary;
    logic backup_supply_summary;
    logic comm_error_summary;
    logic wake_summary;
    logic pre_regulator_summary;
    logic boost_summary;
    logic buck_first_summary;
    logic buck_second_summary;
    logic buck_third_summary;
    logic linear_first_summary;
    logic linear_second_summary;
    logic linear_third_summary;
    logic high_voltage_linear_summary;
    logic standby_timer_summary;
    logic supply_summary;
    logic thermal_selftest_summary;
  } pmc_flag_t;

  typedef struct packed {
    logic        fs_sel;
    logic        wr;
    logic [5:0]  addr;
    logic [15:0] wdata;
    logic        crc_ok;
  } pmc_lreq_t;

  typedef struct packed {
    logic              pre_regulator_off_request;
    logic [RAIL_N-1:0] rail_off_req;
    logic [RAIL_N-1:0] rail_on_req;
  } pmc_rail_req_t;

endpackage

// *** pmc_sync.sv ***
// Two-flop synchroniser for levels and toggles
`timescale 1ns/1ps
`default_nettype none
module pmc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule // pmc_sync
`default_nettype wire

// *** pmc_stby_timer.sv ***
// Standby window timer with millisecond prescaler
`timescale 1ns/1ps
`default_nettype none
module pmc_stby_timer
  import pmc_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [3:0] win_sel,
  output logic            expired
);
  logic [31:0] pre_ff;
  logic [23:0] ms_ff;
  logic        expired_ff;
  logic        tick;

  assign tick = (pre_ff == 32'(TICK_CYC - 1));

  // Stopping the timer restarts the window from zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= '0;
    end else if (!run || tick) begin // R17
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_ff      <= '0;
      expired_ff <= 1'b0;
    end else begin
      expired_ff <= 1'b0;
      if (!run) begin
        ms_ff <= '0;
      end else if (tick) begin
        if (ms_ff == WIN_MS[win_sel] - 24'h1) begin // R18
          ms_ff      <= '0;
          expired_ff <= 1'b1;
        end else begin
          ms_ff <= ms_ff + 24'h1;
        end
      end
    end
  end

  assign expired = expired_ff;
endmodule // pmc_stby_timer
`default_nettype wire

// *** pmc_main_ctrl_sva.sv ***
// Port-level checks for the main control and flag register group
`timescale 1ns/1ps
`default_nettype none
module pmc_main_ctrl_sva
  import pmc_pkg::*;
(
  input wire logic          mclk,
  input wire logic          nrst,
  input wire logic          lk_clk,
  input wire logic          lk_req_valid,
  input wire logic          lk_req_ready,
  input wire logic          lk_rsp_valid,
  input wire logic          wake_input_first,
  input wire logic          wake_input_second,
  input wire logic          otp_deep_sleep_allow,
  input wire logic          wake_first_wake,
  input wire logic          wake_second_wake,
  input wire logic          deep_sleep_request,
  input wire logic          external_sync_deselect,
  input wire logic          enter_off_command,
  input wire pmc_rail_req_t rail_req
);
  sequence take_s;
    lk_req_valid && lk_req_ready;
  endsequence
  // Margin over the sync chain so slower but legal designs pass
  sequence answer_s;
    ##[1:40] lk_rsp_valid;
  endsequence

  link_busy_a: assert property (@(posedge lk_clk) disable iff (!nrst)
    take_s |=> !lk_req_ready) else $error("link ready after take");
  link_answer_a: assert property (@(posedge lk_clk) disable iff (!nrst)
    take_s |-> answer_s) else $error("link request not answered");
  wake_first_a: assert property (@(posedge mclk) disable iff (!nrst)
    !wake_input_first [*6] |-> !wake_first_wake)
    else $error("first wake without input");
  wake_second_a: assert property (@(posedge mclk) disable iff (!nrst)
    !wake_input_second [*6] |-> !wake_second_wake)
    else $error("second wake without input");
  deep_sleep_a: assert property (@(posedge mclk) disable iff (!nrst)
    !otp_deep_sleep_allow [*6] |-> !deep_sleep_request)
    else $error("deep sleep request while not allowed");
  off_pulse_a: assert property (@(posedge mclk) disable iff (!nrst)
    enter_off_command |=> !enter_off_command) else $error("off cmd held");
  ext_pulse_a: assert property (@(posedge mclk) disable iff (!nrst)
    external_sync_deselect |=> !external_sync_deselect)
    else $error("sync deselect held");
  rail_strobe_a: assert property (@(posedge mclk) disable iff (!nrst)
    rail_req != '0 |=> rail_req == '0) else $error("rail request held");
  rail_prio_a: assert property (@(posedge mclk) disable iff (!nrst)
    (rail_req.rail_on_req & rail_req.rail_off_req) == '0)
    else $error("rail on and off together");
endmodule // pmc_main_ctrl_sva

bind pmc_main_ctrl pmc_main_ctrl_sva chk (.mclk, .nrst, .lk_clk,
  .lk_req_valid, .lk_req_ready, .lk_rsp_valid, .wake_input_first,
  .wake_input_second, .otp_deep_sleep_allow, .wake_first_wake,
  .wake_second_wake, .deep_sleep_request, .external_sync_deselect,
  .enter_off_command, .rail_req);
`default_nettype wire

// *** pmc_host.sv ***
// Host requester model for the register access link
`timescale 1ns/1ps
`default_nettype none
module pmc_host
  import pmc_pkg::*;
(
  input  wire logic        lk_clk,
  output logic             lk_req_valid,
  output pmc_lreq_t        lk_req,
  input  wire logic        lk_req_ready,
  input  wire logic        lk_rsp_valid,
  input  wire logic [15:0] lk_rsp_rdata
);
  initial begin
    lk_req_valid = 1'b0;
    lk_req = '0;
  end

  task automatic xfer(input logic fs, input logic wr, input logic [5:0] a,
                      input logic [15:0] wd, input logic ok,
                      input logic [1:0] gap, output logic [15:0] rd);
    int n;
    rd = 'x;
    @(negedge lk_clk);
    while (lk_req_ready !== 1'b1) @(negedge lk_clk);
    repeat (gap) @(posedge lk_clk);
    @(posedge lk_clk);
    lk_req_valid <= 1'b1;
    lk_req <= '{fs, wr, a, wd, ok};
    @(posedge lk_clk);
    lk_req_valid <= 1'b0;
    // Released fields flip so stale values are never mistaken for live
    lk_req <= ~lk_req;
    for (n = 0; n < 40 && lk_rsp_valid !== 1'b1; n++) @(negedge lk_clk);
    if (lk_rsp_valid === 1'b1) rd = lk_rsp_rdata;
  endtask
endmodule // pmc_host
`default_nettype wire

// *** pmc_main_ctrl_tb.sv ***
// Self-checking bench for the main control and flag register group
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end
module pmc_main_ctrl_tb
  import pmc_pkg::*;
;
  localparam int unsigned TK = 4;
  logic          mclk = 1'b0, lk_clk = 1'b0, nrst = 1'b0;
  logic          lk_req_valid, lk_req_ready, lk_rsp_valid;
  logic [15:0]   lk_rsp_rdata, rnd, w, r;
  pmc_lreq_t     lk_req;
  pmc_src_t      src_flags;
  logic          pll_locked_in, normal_state_in, pgood_in, wake_input_first;
  logic          wake_input_second, otp_pgood_test_allow, otp_deep_sleep_allow;
  logic          otp_standby_timer_enable, stby_timer_flag_clr;
  logic          standby_power_good_output, wake_first_wake, wake_second_wake;
  logic          deep_sleep_request, external_sync_deselect, enter_off_command;
  logic          standby_timer_expired;
  pmc_rail_req_t rail_req, acc;
  logic          acc_clr = 1'b1;
  int            failures, checks_done, n_off, n_ext, e;

  pmc_main_ctrl #(.TICK_CYC(TK)) dut (.mclk, .nrst, .lk_clk, .lk_req_valid,
    .lk_req, .lk_req_ready, .lk_rsp_valid, .lk_rsp_rdata, .src_flags,
    .pll_locked_in, .normal_state_in, .pgood_in, .wake_input_first,
    .wake_input_second, .otp_pgood_test_allow, .otp_deep_sleep_allow,
    .otp_standby_timer_enable, .stby_timer_flag_clr, .standby_power_good_output,
    .wake_first_wake, .wake_second_wake, .deep_sleep_request,
    .external_sync_deselect, .enter_off_command, .standby_timer_expired,
    .rail_req);
  pmc_host host (.lk_clk, .lk_req_valid, .lk_req, .lk_req_ready,
    .lk_rsp_valid, .lk_rsp_rdata);

  always #25 mclk = ~mclk;
  always #7.5 lk_clk = ~lk_clk;

  always @(posedge mclk) begin
    if (enter_off_command === 1'b1) n_off <= n_off + 1;
    if (external_sync_deselect === 1'b1) n_ext <= n_ext + 1;
    acc <= acc_clr ? '0 : acc | rail_req;
  end

  function automatic logic [15:0] lf(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic [15:0] fexp(input pmc_src_t s, input logic t);
    return {s.die_temp_flag, s.backup_uvh, s.crc_err | s.req_err,
            s.wake_first_flag | s.wake_second_flag,
            s.pre_oc | s.pre_uvh | s.pre_uvl | s.pre_fb_ov,
            s.boost_ot | s.boost_ov,
            s.buck_oc[0] | s.buck_ot[0], s.buck_oc[1] | s.buck_ot[1],
            s.buck_oc[2] | s.buck_ot[2], s.ldo_oc[0] | s.ldo_ot[0],
            s.ldo_oc[1] | s.ldo_ot[1], s.ldo_oc[2] | s.ldo_ot[2],
            s.hv_oc | s.hv_ot | s.hv_in_uvl, t,
            s.sup_uvh | s.sup_uvt | s.sup_uv7, s.tsd_bist_err};
  endfunction

  task automatic xf(input logic wr, input logic [5:0] a, input logic [15:0] d,
                    input logic fs = 1'b0, input logic ok = 1'b1);
    rnd = lf(rnd);
    host.xfer(fs, wr, a, d, ok, rnd[1:0], r);
  endtask

  task automatic nw(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #500_000;
    failures++;
    final_report();
  end

  initial begin
    rnd = 16'h0010;
    src_flags = '0;
    {pll_locked_in, normal_state_in, pgood_in, wake_input_first,
     wake_input_second, otp_pgood_test_allow, otp_deep_sleep_allow,
     otp_standby_timer_enable, stby_timer_flag_clr} = '0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    nw(10);
    xf(0, ADDR_MODE, 0);
    `CHK(r, MODE_RST)
    xf(0, 6'h3f, 0);
    `CHK(r, 16'h0000)
    for (int i = 0; i < 12; i++) begin
      rnd = lf(rnd);
      @(posedge mclk);
      src_flags <= i == 0 ? '1 : i == 1 ? '0 : {rnd[14:0], lf(rnd)};
      nw(5);
      if (i == 2) xf(1, ADDR_FLAG, 16'hffff);
      xf(0, ADDR_FLAG, 0);
      `CHK(r, fexp(src_flags, 1'b0))
    end
    for (int i = 0; i < 10; i++) begin
      rnd = lf(rnd);
      w = i == 0 ? 16'hffff : lf(rnd);
      @(posedge mclk);
      {pll_locked_in, normal_state_in, pgood_in, wake_input_first,
       wake_input_second, otp_pgood_test_allow, otp_deep_sleep_allow}
        <= rnd[6:0];
      e = n_ext;
      xf(1, ADDR_MODE, w);
      nw(8);
      xf(0, ADDR_MODE, 0);
      `CHK(r, {8'h00, pll_locked_in, 1'b0, normal_state_in, w[4:0]})
      `CHK(wake_first_wake, wake_input_first & ~w[1])
      `CHK(wake_second_wake, wake_input_second & ~w[2])
      `CHK(deep_sleep_request,
           wake_input_second & w[4] & otp_deep_sleep_allow)
      `CHK(standby_power_good_output,
           (w[0] & otp_pgood_test_allow) ? w[3] : pgood_in)
      xf(1, ADDR_MODE, ~w, i[0], i[0]);
      xf(0, ADDR_MODE, 0);
      `CHK(r[4:0], w[4:0])
      `CHK(n_ext, e + int'(w[6]))
    end
    e = n_off;
    xf(1, ADDR_SMCTL, 16'h0001);
    nw(4);
    `CHK(n_off, e + 1)
    xf(0, ADDR_SMCTL, 0);
    `CHK(r, 16'h0000)
    `CHK(standby_timer_expired, 1'b0)
    xf(1, ADDR_SMCTL, 16'h0400);
    nw(45);
    `CHK(standby_timer_expired, 1'b0)
    nw(30);
    `CHK(standby_timer_expired, 1'b1)
    xf(0, ADDR_FLAG, 0);
    `CHK(r, fexp(src_flags, 1'b1))
    xf(1, ADDR_SMCTL, 16'hf000);
    xf(0, ADDR_SMCTL, 0);
    `CHK(r, 16'hf000)
    // Timer is stopped now, so nothing can set the flag again
    @(posedge mclk);
    stby_timer_flag_clr <= 1'b1;
    @(posedge mclk);
    stby_timer_flag_clr <= 1'b0;
    nw(2);
    `CHK(standby_timer_expired, 1'b0)
    for (int i = 0; i < 10; i++) begin
      rnd = lf(rnd);
      w = i == 0 ? 16'hffff : i == 1 ? 16'h007f : rnd;
      @(negedge mclk);
      acc_clr = 1'b1;
      @(negedge mclk);
      acc_clr = 1'b0;
      xf(1, ADDR_RAILREQ, w);
      nw(4);
      `CHK(acc, {w[15], w[14:8], w[6:0] & ~w[14:8]})
      xf(0, ADDR_RAILREQ, 0);
      `CHK(r, 16'h0000)
    end
    final_report();
  end
endmodule // pmc_main_ctrl_tb
`default_nettype wire
